// ---- inc/sdr_pkg.sv ----
// register map, field layout, reset values and state carrier
package sdr_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_STCTRL = 8'h16; // self-test control
    localparam logic [7:0] IDX_ERRGAP = 8'h1b; // error count and gap
    localparam logic [7:0] IDX_PKTLEN = 8'h1c; // packet length
    localparam logic [7:0] IDX_DIAG   = 8'h1e; // cable diagnostics
    localparam logic [7:0] IDX_RSTCTL = 8'h1f; // reset control
    localparam logic [7:0] IDX_IRQSTS = 8'h20; // event status, w1c
    localparam logic [7:0] IDX_IRQMSK = 8'h21; // event mask

    // field positions
    localparam int ERR_LO     = 8;  // error count low bit
    localparam int ERR_CLR    = 15; // capture and clear
    localparam int CTL_LOCKA  = 0;  // lock strobe a
    localparam int CTL_LOCKB  = 1;  // lock strobe b
    localparam int CTL_MODE   = 2;  // count mode
    localparam int CTL_LOCKED = 3;  // lock status
    localparam int DG_START   = 15; // diagnostic start
    localparam int DG_QLO     = 8;  // link quality low bit
    localparam int DG_DONE    = 1;  // diagnostic done
    localparam int DG_FAIL    = 0;  // diagnostic fail
    localparam int RC_RESET   = 15; // software reset
    localparam int RC_RESTART = 14; // software restart
    localparam int EV_DONE    = 0;  // event: diag done
    localparam int EV_FAIL    = 1;  // event: diag fail
    localparam int EV_SAT     = 2;  // event: counter full

    // reset values and limits
    localparam logic [7:0]  GAP_RST = 8'h7d;   // 125 bytes
    localparam logic [10:0] LEN_RST = 11'h5dc; // 1500 bytes
    localparam logic [7:0]  CNT_MAX = 8'hff;   // counter ceiling

    // result of the cable measurement engine
    typedef struct packed {
        logic       done;    // one-cycle completion pulse
        logic       fail;    // failure flag, valid with done
        logic [1:0] quality; // link quality code
    } sdr_diag_s;

    // whole state of the register bank
    typedef struct packed {
        logic [7:0]  cnt;   // running error counter
        logic [7:0]  snap;  // frozen count for software
        logic        lock;  // software sees the snapshot
        logic        mode;  // 0: saturate, 1: wrap
        logic [7:0]  gap;   // inter-packet gap bytes
        logic [10:0] len;   // packet length bytes
        logic        start; // diagnostic running
        logic        done;  // diagnostic done
        logic        fail;  // diagnostic failed
        logic [1:0]  qual;  // latched link quality
        logic [2:0]  sts;   // sticky events
        logic [2:0]  msk;   // event mask
        logic        irq;   // interrupt line
        logic [31:0] rdata; // apb read data
        logic        rdy;   // apb ready
        logic        err;   // apb slave error
        logic        rstP;  // soft reset pulse
        logic        rstrP; // restart pulse
    } sdr_state_s;

    localparam sdr_state_s ST_RST = '{
        cnt: 8'h00, snap: 8'h00, lock: 1'b0, mode: 1'b0,
        gap: GAP_RST, len: LEN_RST, start: 1'b0, done: 1'b0,
        fail: 1'b0, qual: 2'b00, sts: 3'h0, msk: 3'h0, irq: 1'b0,
        rdata: 32'h0000_0000, rdy: 1'b0, err: 1'b0, rstP: 1'b0,
        rstrP: 1'b0
    };

endpackage

// ---- rtl/sdr_regs.sv ----
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
// Contract
// R1: upper byte reports erroneous checker byte count
// R2: write to control bits 0/1 freezes count
// R3: count mode zero saturates counter at ff
// R4: bit 15 write captures count, clears counter
// R5: generator gap from low byte, reset 125
// R6: packet length 11-bit field, reset 1500
// R7: reserved bits ignore writes, read zero
// R8: diagnostic runs only while start set
// R9: start clears when done indication sets
// R10: link quality 01 good, 10 mid, 11 poor
// R11: quality valid only while link is up; no link input here, the latched quality reads at any time
// R12: done bit reads one after measurement completes
// R13: fail bit reads one after failed measurement
// R14: software reset acts like hardware reset
// R15: software restart resets circuitry, keeps registers
// R16: self-clearing reset bits read back zero
module sdr_regs
    import sdr_pkg::*;
(
    // clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // prbs checker
    input  wire logic        prbsErrByte,
    // cable measurement engine
    input  wire sdr_diag_s   diagIn,
    output logic             diagRun,
    // packet generator
    output logic [7:0]       gapBytes,
    output logic [10:0]      pktLen,
    // reset lines and interrupt
    output logic             swResetPulse,
    output logic             swRestartPulse,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////
    // register map at a glance, word index then fields
    //   16 self-test control: lock strobes 1:0, mode 2, lock flag 3
    //   1b error count 15:8 read-only, gap 7:0, bit 15 captures
    //   1c packet length 10:0, upper bits read zero
    //   1e diagnostics: start 15, quality 9:8, done 1, fail 0
    //   1f reset control: soft reset 15, restart 14, reads zero
    //   20 sticky events, write one to clear
    //   21 event mask, same layout as the events
    // event bits: 0 diagnostic done, 1 diagnostic failed,
    // 2 error counter reached its ceiling
    // every word is 32 bits wide on the bus; only the low 16
    // carry fields, the rest always read as zero
    // the bus is answered after one wait-free access phase;
    // read data comes from a flop, so decode depth never sets
    // the timing of prdata

    ////////////////////////////////////////////////////////////////
    // address decode helpers

    // word index of a byte address
    function automatic logic [7:0] regIdx(input logic [9:0] a);
        regIdx = a[9:2];
    endfunction

    // true when the index names a mapped register
    function automatic logic isMapped(input logic [7:0] i);
        isMapped = (i == IDX_STCTRL) || (i == IDX_ERRGAP) ||
                   (i == IDX_PKTLEN) || (i == IDX_DIAG) ||
                   (i == IDX_RSTCTL) || (i == IDX_IRQSTS) ||
                   (i == IDX_IRQMSK);
    endfunction

    sdr_state_s st_r;   // registered state
    sdr_state_s st_nxt; // next state

    logic       setup;  // apb setup cycle
    logic       commit; // access edge with ready high
    logic [7:0] idx;    // decoded register index
    logic       wrOk;   // committed write to mapped word
    logic [2:0] ev;     // events this cycle
    logic [7:0] view;   // count shown to software

    assign setup  = psel && !penable && !st_r.rdy;
    assign commit = psel && penable && st_r.rdy;
    assign idx    = regIdx(paddr);
    assign wrOk   = commit && pwrite && !st_r.err;
    // frozen value wins while locked
    assign view   = st_r.lock ? st_r.snap : st_r.cnt;

    ////////////////////////////////////////////////////////////////
    // next-state logic
    // later assignments override earlier ones on purpose:
    //   counter step, then engine result, then bus access,
    //   then sticky events, and a soft reset last of all
    // so a capture-and-clear beats an error byte in the same
    // cycle, and a soft reset beats every other write effect
    // limitation: a start write landing with a done pulse
    // begins a new run and clears that done and fail; its quality and events are kept
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rstP  = 1'b0;
        st_nxt.rstrP = 1'b0;
        ev = 3'h0;

        // prbs error counter
        if (prbsErrByte)
        begin
            // R3: saturate in mode zero
            if (st_r.cnt == CNT_MAX && !st_r.mode)
                st_nxt.cnt = CNT_MAX;
            else
                st_nxt.cnt = st_r.cnt + 8'h01;
            // first touch of the ceiling is an event
            if (st_r.cnt == (CNT_MAX - 8'h01))
                ev[EV_SAT] = 1'b1;
        end

        // cable engine result
        if (st_r.start && diagIn.done)
        begin
            // R12: latch completion
            st_nxt.done = 1'b1;
            // R13: latch failure
            st_nxt.fail = diagIn.fail;
            st_nxt.qual = diagIn.quality;
            // R9: start falls with done
            st_nxt.start = 1'b0;
            ev[EV_DONE] = 1'b1;
            ev[EV_FAIL] = diagIn.fail;
        end

        // apb: answer one cycle after setup, data from a flop
        st_nxt.rdy = setup;
        if (setup)
        begin
            st_nxt.err   = !isMapped(idx) || (paddr[1:0] != 2'b00);
            st_nxt.rdata = 32'h0000_0000;
            // R7: unlisted bits stay zero
            unique case (idx)
                IDX_STCTRL:
                begin
                    st_nxt.rdata[CTL_MODE]   = st_r.mode;
                    st_nxt.rdata[CTL_LOCKED] = st_r.lock;
                end
                // R1: count in the upper byte
                IDX_ERRGAP:
                    st_nxt.rdata[15:0] = {view, st_r.gap};
                IDX_PKTLEN:
                    st_nxt.rdata[10:0] = st_r.len;
                IDX_DIAG:
                begin
                    st_nxt.rdata[DG_START] = st_r.start;
                    // R10: quality code as measured
                    st_nxt.rdata[DG_QLO+1:DG_QLO] = st_r.qual;
                    st_nxt.rdata[DG_DONE] = st_r.done;
                    st_nxt.rdata[DG_FAIL] = st_r.fail;
                end
                // R16: reset bits always read zero
                IDX_RSTCTL:
                    st_nxt.rdata = 32'h0000_0000;
                IDX_IRQSTS:
                    st_nxt.rdata[2:0] = st_r.sts;
                IDX_IRQMSK:
                    st_nxt.rdata[2:0] = st_r.msk;
                default:
                    st_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // software writes at the access edge
        if (wrOk)
        begin
            unique case (idx)
                IDX_STCTRL:
                begin
                    st_nxt.mode = pwdata[CTL_MODE];
                    // R2: either strobe freezes the view
                    if (pwdata[CTL_LOCKA] || pwdata[CTL_LOCKB])
                    begin
                        st_nxt.lock = 1'b1;
                        st_nxt.snap = st_r.cnt;
                    end
                    else
                        st_nxt.lock = 1'b0;
                end
                IDX_ERRGAP:
                begin
                    // R5: gap for the generator
                    st_nxt.gap = pwdata[7:0];
                    // R4: capture then clear the counter
                    if (pwdata[ERR_CLR])
                    begin
                        st_nxt.snap = st_r.cnt;
                        st_nxt.lock = 1'b1;
                        st_nxt.cnt  = 8'h00;
                    end
                end
                // R6: 11-bit length, upper bits dropped
                IDX_PKTLEN:
                    st_nxt.len = pwdata[10:0];
                IDX_DIAG:
                begin
                    // R8: start launches, zero stops
                    st_nxt.start = pwdata[DG_START];
                    // a new run drops the old verdict
                    if (pwdata[DG_START])
                    begin
                        st_nxt.done = 1'b0;
                        st_nxt.fail = 1'b0;
                    end
                end
                IDX_RSTCTL:
                begin
                    // R15: pulse only, registers kept
                    st_nxt.rstrP = pwdata[RC_RESTART];
                end
                IDX_IRQMSK:
                    st_nxt.msk = pwdata[2:0];
                default:
                    st_nxt.msk = st_r.msk;
            endcase
        end

        // sticky events; a fresh event beats a w1c clear
        if (wrOk && idx == IDX_IRQSTS)
            st_nxt.sts = (st_r.sts & ~pwdata[2:0]) | ev;
        else
            st_nxt.sts = st_r.sts | ev;
        st_nxt.irq = |(st_nxt.sts & st_nxt.msk);

        // R14: whole bank back to reset values, pulse out
        if (wrOk && idx == IDX_RSTCTL && pwdata[RC_RESET])
        begin
            st_nxt      = ST_RST;
            st_nxt.rstP = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // state register; enable low freezes everything
    // the whole bank sits in one struct, so a frozen enable
    // also holds a pending bus answer; the master simply waits
    // reset values come from one constant shared with soft reset
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            st_r <= ST_RST;
        else if (ce)
            st_r <= st_nxt;
    end

    ////////////////////////////////////////////////////////////////
    // outputs straight from the state flops
    assign prdata         = st_r.rdata;
    assign pready         = st_r.rdy;
    assign pslverr        = st_r.err;
    // R8: engine active only while start holds
    assign diagRun        = st_r.start;
    assign gapBytes       = st_r.gap;
    assign pktLen         = st_r.len;
    assign swResetPulse   = st_r.rstP;
    assign swRestartPulse = st_r.rstrP;
    assign irq            = st_r.irq;

    ////////////////////////////////////////////////////////////////
    // checks
    // all checks share the core clock; a hardware reset
    // disables them, a soft reset does not, so every property
    // below must also hold across a soft reset
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // committed write to a given word
    sequence sWr(logic [7:0] i);
        ce && wrOk && idx == i;
    endsequence

    // soft reset pulse then quiet
    sequence sRstPulse;
        swResetPulse ##1 (!swResetPulse || !$past(ce));
    endsequence

    // engine reports completion to a running diagnostic
    sequence sDiagEnd;
        ce && diagRun && diagIn.done && !wrOk;
    endsequence

    // access edge of an accepted read of a given word
    sequence sRd(logic [7:0] i);
        pready && psel && penable && !pwrite && !pslverr && idx == i;
    endsequence

    AST_SAT: assert property ( // R3
        ce && prbsErrByte && !st_r.mode && st_r.cnt == CNT_MAX && !wrOk
        |=> st_r.cnt == CNT_MAX)
        else $error("counter left its ceiling");

    AST_LOCK: assert property ( // R2
        sWr(IDX_STCTRL) ##0 (pwdata[1:0] != 2'b00)
        |=> st_r.lock && st_r.snap == $past(st_r.cnt))
        else $error("lock strobe did not freeze count");

    AST_CLR: assert property ( // R4
        sWr(IDX_ERRGAP) ##0 pwdata[ERR_CLR] && !prbsErrByte
        |=> st_r.cnt == 8'h00 && st_r.lock)
        else $error("capture and clear failed");

    AST_GAP: assert property ( // R5
        sWr(IDX_ERRGAP) |=> gapBytes == $past(pwdata[7:0]))
        else $error("gap not taken from write");

    AST_LEN: assert property ( // R6
        sWr(IDX_PKTLEN) |=> pktLen == $past(pwdata[10:0]))
        else $error("packet length not taken");

    AST_RSV: assert property ( // R7
        pready && psel && !pwrite && idx == IDX_PKTLEN
        |-> prdata[31:11] == 21'h000000)
        else $error("reserved bits read nonzero");

    AST_DONE: assert property ( // R9
        ce && diagRun && diagIn.done && !wrOk
        |=> !diagRun && st_r.done ##1 (!diagRun || $past(wrOk)))
        else $error("start not cleared by done");

    AST_FAIL: assert property ( // R13
        ce && diagRun && diagIn.done && !wrOk
        |=> st_r.fail == $past(diagIn.fail))
        else $error("fail bit wrong");

    AST_SRST: assert property ( // R14
        sWr(IDX_RSTCTL) ##0 pwdata[RC_RESET]
        |=> pktLen == LEN_RST && gapBytes == GAP_RST ##0 sRstPulse)
        else $error("soft reset did not restore bank");

    AST_RSTR: assert property ( // R15
        sWr(IDX_RSTCTL) ##0 pwdata[RC_RESTART] && !pwdata[RC_RESET]
        |=> swRestartPulse && pktLen == $past(pktLen))
        else $error("restart lost registers");

    AST_RDZ: assert property ( // R16
        pready && psel && !pwrite && idx == IDX_RSTCTL
        |-> prdata == 32'h0000_0000)
        else $error("reset bits read nonzero");

    AST_CNTRD: assert property ( // R1
        sRd(IDX_ERRGAP) |-> prdata[15:8] == $past(view))
        else $error("error count read wrong");

    AST_IDLE: assert property ( // R8
        ce && !diagRun && diagIn.done && !wrOk |=> !diagRun && !$rose(st_r.done))
        else $error("idle engine result was taken");

    AST_QUAL: assert property ( // R10
        sDiagEnd |=> st_r.qual == $past(diagIn.quality))
        else $error("link quality not latched");

    AST_DONERD: assert property ( // R12
        sRd(IDX_DIAG) |-> prdata[DG_DONE] == $past(st_r.done))
        else $error("done bit read wrong");

    AST_SC: assert property ( // R16
        ce && (swResetPulse || swRestartPulse) |=> !swResetPulse && !swRestartPulse)
        else $error("reset control bit did not clear");

endmodule

// ---- verif/sdr_regs_bench.sv ----
`timescale 1ns/1ps
module sdr_regs_bench;
    import sdr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // stimulus and observed signals
    logic        sys_clk;        // 100 MHz core clock
    logic        arst_n;         // hardware reset, active low
    logic        ce;             // clock enable, high except in the enable-low test
    logic        psel;           // apb select
    logic        penable;        // apb access phase
    logic        pwrite;         // apb direction
    logic [9:0]  paddr;          // apb byte address
    logic [31:0] pwdata;         // apb write data
    logic [31:0] prdata;         // apb read data
    logic        pready;         // apb ready
    logic        pslverr;        // apb error
    logic        prbsErrByte;    // checker error byte strobe
    sdr_diag_s   diagIn;         // measurement engine result
    logic        diagRun;        // engine enable
    logic [7:0]  gapBytes;       // generator gap
    logic [10:0] pktLen;         // generator length
    logic        swResetPulse;   // soft reset strobe
    logic        swRestartPulse; // restart strobe
    logic        irq;            // interrupt line
    logic [31:0] rdv;            // last read data
    logic        erv;            // last slave error
    int          miscompares;    // mismatch count
    int          nCompared;      // comparison count
    int          nReset;         // soft reset strobes seen
    int          nRestart;       // restart strobes seen

    sdr_regs i_dut (
        .sys_clk        (sys_clk),
        .arst_n         (arst_n),
        .ce             (ce),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .paddr          (paddr),
        .pwdata         (pwdata),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .prbsErrByte    (prbsErrByte),
        .diagIn         (diagIn),
        .diagRun        (diagRun),
        .gapBytes       (gapBytes),
        .pktLen         (pktLen),
        .swResetPulse   (swResetPulse),
        .swRestartPulse (swRestartPulse),
        .irq            (irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock and strobe counters; one-cycle strobes are caught on every edge
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        if (swResetPulse === 1'b1) nReset++;
        if (swRestartPulse === 1'b1) nRestart++;
    end

    ////////////////////////////////////////////////////////////////////////
    // compare and verdict
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic printVerdict();
        if (miscompares == 0 && nCompared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // apb master: setup, then access until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        // no count of its own; a hang is cut by the watchdog
        do
        begin
            @(posedge sys_clk);
        end
        while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        chk("read", rdv, exp);
    endtask

    // let the commit edge land before looking at registered outputs
    task automatic settle();
        @(posedge sys_clk);
        #1;
    endtask

    // n consecutive cycles of checker error bytes
    task automatic errs(input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            prbsErrByte <= 1'b1;
        end
        @(posedge sys_clk);
        prbsErrByte <= 1'b0;
    endtask

    // one-cycle completion from the measurement engine
    task automatic dg(input logic f, input logic [1:0] q);
        @(posedge sys_clk);
        diagIn <= '{1'b1, f, q};
        @(posedge sys_clk);
        diagIn <= '0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watchdog: the whole sequence needs about 720 cycles
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        printVerdict();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        arst_n = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; prbsErrByte = 1'b0; diagIn = '0;
        miscompares = 0; nCompared = 0; nReset = 0; nRestart = 0;
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        settle();
        chk("gapBytes", gapBytes, 32'h7d);
        chk("pktLen", pktLen, 32'h5dc);
        rd(IDX_ERRGAP, 32'h0000_007d);
        rd(IDX_PKTLEN, 32'h0000_05dc);
        rd(IDX_DIAG, 32'h0000_0000);
        rd(IDX_RSTCTL, 32'h0000_0000);
        // reserved and read-only bits take no write
        wr(IDX_PKTLEN, 32'hffff_fabc);
        rd(IDX_PKTLEN, 32'h0000_02bc);
        chk("pktLen", pktLen, 32'h2bc);
        wr(IDX_ERRGAP, 32'h0000_7f10);
        rd(IDX_ERRGAP, 32'h0000_0010);
        chk("gapBytes", gapBytes, 32'h10);
        // counting, capture-and-clear, freeze by control writes
        errs(5);
        rd(IDX_ERRGAP, 32'h0000_0510);
        wr(IDX_ERRGAP, 32'h0000_8010);
        errs(3);
        rd(IDX_ERRGAP, 32'h0000_0510);
        wr(IDX_STCTRL, 32'h0000_0000);
        rd(IDX_ERRGAP, 32'h0000_0310);
        wr(IDX_STCTRL, 32'h0000_0001);
        errs(4);
        rd(IDX_ERRGAP, 32'h0000_0310);
        wr(IDX_STCTRL, 32'h0000_0002);
        rd(IDX_ERRGAP, 32'h0000_0710);
        wr(IDX_STCTRL, 32'h0000_0000);
        // saturation in count mode zero raises the full event
        wr(IDX_IRQMSK, 32'h0000_0004);
        errs(260);
        rd(IDX_ERRGAP, 32'h0000_ff10);
        chk("irq", irq, 32'h1);
        wr(IDX_ERRGAP, 32'h0000_8010);
        wr(IDX_STCTRL, 32'h0000_0000);
        wr(IDX_IRQSTS, 32'h0000_0004);
        rd(IDX_IRQSTS, 32'h0000_0000);
        chk("irq", irq, 32'h0);
        // wrap mode does not stop at the ceiling
        wr(IDX_STCTRL, 32'h0000_0004);
        errs(256);
        rd(IDX_ERRGAP, 32'h0000_0010);
        rd(IDX_IRQSTS, 32'h0000_0004);
        wr(IDX_IRQSTS, 32'h0000_0004);
        wr(IDX_STCTRL, 32'h0000_0000);
        // enable low: error bytes are not counted
        @(posedge sys_clk);
        ce <= 1'b0;
        errs(3);
        ce <= 1'b1;
        rd(IDX_ERRGAP, 32'h0000_0010);
        // completion while idle is ignored
        dg(1'b1, 2'b01);
        rd(IDX_DIAG, 32'h0000_0000);
        chk("diagRun", diagRun, 32'h0);
        // each quality code, fail only with the poorest
        // link taken as up, so quality is trusted
        for (int q = 1; q < 4; q++)
        begin
            wr(IDX_DIAG, 32'h0000_8000);
            settle();
            chk("diagRun", diagRun, 32'h1);
            rd(IDX_DIAG, 32'h8000 | ((q - 1) << 8));
            dg(q == 3, q[1:0]);
            rd(IDX_DIAG, (q << 8) | 32'h2 | (q == 3));
            chk("diagRun", diagRun, 32'h0);
        end
        // done and fail events, masking and write-one-to-clear
        rd(IDX_IRQSTS, 32'h0000_0003);
        chk("irq", irq, 32'h0);
        wr(IDX_IRQMSK, 32'h0000_0001);
        settle();
        chk("irq", irq, 32'h1);
        wr(IDX_IRQSTS, 32'h0000_0001);
        settle();
        chk("irq", irq, 32'h0);
        rd(IDX_IRQSTS, 32'h0000_0002);
        // unmapped place answers with an error and zero data
        apb(1'b0, 8'hff, 32'h0000_0000);
        chk("pslverr", erv, 32'h1);
        chk("prdata", rdv, 32'h0);
        // restart keeps register contents
        wr(IDX_RSTCTL, 32'h0000_4000);
        rd(IDX_RSTCTL, 32'h0000_0000);
        chk("pktLen", pktLen, 32'h2bc);
        chk("restarts", nRestart, 32'h1);
        // soft reset returns the bank to its reset values
        wr(IDX_RSTCTL, 32'h0000_8000);
        settle();
        settle();
        chk("resets", nReset, 32'h1);
        chk("gapBytes", gapBytes, 32'h7d);
        chk("pktLen", pktLen, 32'h5dc);
        rd(IDX_IRQMSK, 32'h0000_0000);
        rd(IDX_RSTCTL, 32'h0000_0000);
        printVerdict();
    end
endmodule
